/* File: core/crc_unit.sv */
/*
 * APB slave of the checksum unit: CRC32 word engine with self-clearing
 * reinit, CRC16 byte engine with clear, seed and bit-order control, and an
 * 8-bit XOR checksum updated alongside the CRC16.
 * Assumes an APB4 master on pclk with byte strobes; one wait state per access.
 */
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
// How it works
// - crc32 reinit loads all ones
// - crc32 reinit bit self-clears after one cycle
// - crc16 clear zeroes result, one-cycle pulse
// - crc16 clear bit always reads zero
// - bit order: 0 msb first, 1 lsb first
// - bit order never touches stored result
// - input register takes low data byte
// - byte, halfword, word access via strobes
// - each input write with pstrb[0] set updates crc16 result
// - crc16 poly 0x8005, one byte per cycle
// - seed is previous result or written value
// - crc32 word write folds into result
// - crc32 uses ethernet polynomial
module crc_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] crc32_value;
    logic [7:0] crc32_scratch;
    logic crc32_reset_pending;
    logic bit_order;
    logic clear_pending;
    logic [7:0] input_byte;
    logic [15:0] crc16_value;
    logic [7:0] xor_value;

    logic access;
    logic wr_done;
    logic mapped;
    logic [31:0] read_word;
    logic [15:0] next_crc16;
    logic [31:0] next_crc32;

    logic hit_crc32;
    logic hit_scratch;
    logic hit_reset;
    logic hit_ctrl;
    logic hit_input;
    logic hit_result;
    logic hit_xor;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    assign access = psel & penable;
    assign wr_done = access & pready & pwrite & ~pslverr;

    assign hit_crc32 = paddr == crc_unit_pkg::off_crc32_result_data;
    assign hit_scratch = paddr == crc_unit_pkg::off_crc32_scratch;
    assign hit_reset = paddr == crc_unit_pkg::off_crc32_engine_reset_control;
    assign hit_ctrl = paddr == crc_unit_pkg::off_crc16_control;
    assign hit_input = paddr == crc_unit_pkg::off_crc16_input_byte;
    assign hit_result = paddr == crc_unit_pkg::off_crc16_result;
    assign hit_xor = paddr == crc_unit_pkg::off_xor_checksum_result;
    assign mapped = hit_crc32 | hit_scratch | hit_reset | hit_ctrl | hit_input | hit_result | hit_xor;

    // reserved bits and the clear bit read as zero
    always_comb begin
        read_word = 32'h0000_0000;
        case (1'b1)
            hit_crc32: read_word = crc32_value;
            hit_scratch: read_word[7:0] = crc32_scratch;
            hit_reset: read_word[crc_unit_pkg::crc32_reset_pos] = crc32_reset_pending;
            hit_ctrl: read_word[crc_unit_pkg::input_bit_order_select_pos] = bit_order;
            hit_input: read_word[7:0] = input_byte;
            hit_result: read_word[15:0] = crc16_value;
            hit_xor: read_word[7:0] = xor_value;
            default: read_word = 32'h0000_0000;
        endcase
    end

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite) begin
                prdata <= mapped ? read_word : 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // engines
    // ------------------------------------------------------------
    crc16_byte_step u_crc16 (
        .data(pwdata[7:0]),
        .lsb_first(bit_order),
        .crc_in(crc16_value),
        .crc_out(next_crc16)
    );

    crc32_word_step u_crc32 (
        .data(pwdata),
        .crc_in(crc32_value),
        .crc_out(next_crc32)
    );

    // ------------------------------------------------------------
    // crc32 result and reinit
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc32_value <= crc_unit_pkg::crc32_init;
        end else if (crc32_reset_pending) begin
            crc32_value <= crc_unit_pkg::crc32_init;
        end else if (wr_done & hit_crc32 & (pstrb == crc_unit_pkg::strobe_word)) begin
            crc32_value <= next_crc32;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc32_reset_pending <= 1'b0;
        end else if (wr_done & hit_reset & pstrb[0] & pwdata[crc_unit_pkg::crc32_reset_pos]) begin
            crc32_reset_pending <= 1'b1;
        end else begin
            crc32_reset_pending <= 1'b0;
        end
    end

    // scratch byte is untouched by the reinit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc32_scratch <= crc_unit_pkg::byte_reset_value;
        end else if (wr_done & hit_scratch & pstrb[0]) begin
            crc32_scratch <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // crc16 control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_order <= 1'b0;
        end else if (wr_done & hit_ctrl & pstrb[0]) begin
            bit_order <= pwdata[crc_unit_pkg::input_bit_order_select_pos];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_pending <= 1'b0;
        end else begin
            clear_pending <= wr_done & hit_ctrl & pstrb[0] & pwdata[crc_unit_pkg::crc16_clear_bit_pos];
        end
    end

    // ------------------------------------------------------------
    // crc16 data path
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_byte <= crc_unit_pkg::byte_reset_value;
        end else if (wr_done & hit_input & pstrb[0]) begin
            input_byte <= pwdata[7:0];
        end
    end

    // result lanes written separately so two byte writes seed all 16 bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc16_value <= crc_unit_pkg::crc16_reset_value;
        end else if (clear_pending) begin
            crc16_value <= crc_unit_pkg::crc16_reset_value;
        end else if (wr_done & hit_input & pstrb[0]) begin
            crc16_value <= next_crc16;
        end else if (wr_done & hit_result) begin
            if (pstrb[0]) begin
                crc16_value[7:0] <= pwdata[7:0];
            end
            if (pstrb[1]) begin
                crc16_value[15:8] <= pwdata[15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xor_value <= crc_unit_pkg::byte_reset_value;
        end else if (wr_done & hit_input & pstrb[0]) begin
            xor_value <= xor_value ^ pwdata[7:0];
        end else if (wr_done & hit_xor & pstrb[0]) begin
            xor_value <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_crc32_reinit;
        @(posedge pclk) disable iff (!presetn)
        crc32_reset_pending |=> (crc32_value == crc_unit_pkg::crc32_init);
    endproperty
    a_crc32_reinit: assert property (p_crc32_reinit) else $error("crc32 not all ones after reinit");

    property p_crc32_reset_selfclear;
        @(posedge pclk) disable iff (!presetn)
        crc32_reset_pending |=> !crc32_reset_pending;
    endproperty
    a_crc32_reset_selfclear: assert property (p_crc32_reset_selfclear) else $error("reinit bit stuck");

    property p_clear_zero;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_ctrl && pstrb[0] && pwdata[2])
            |=> clear_pending ##1 (!clear_pending && crc16_value == 16'h0000);
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("crc16 clear did not zero result");

    property p_clear_reads_zero;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && hit_ctrl) |=> (prdata[2] == 1'b0 && prdata[0] == 1'b0);
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("control read shows clear bit");

    property p_order_keeps_result;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_ctrl && !pwdata[2]) |=> $stable(crc16_value);
    endproperty
    a_order_keeps_result: assert property (p_order_keeps_result) else $error("order write moved result");

    property p_input_updates;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_input && pstrb[0] && !clear_pending) |=> (crc16_value == $past(next_crc16));
    endproperty
    a_input_updates: assert property (p_input_updates) else $error("crc16 not updated on input write");

    property p_xor_update;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_input && pstrb[0]) |=> (xor_value == ($past(xor_value) ^ $past(pwdata[7:0])));
    endproperty
    a_xor_update: assert property (p_xor_update) else $error("checksum not xored with byte");

    property p_crc16_known_vector;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_input && pstrb[0] && !bit_order && !clear_pending && crc16_value == 16'h0000
            && pwdata[7:0] == 8'h01) |=> (crc16_value == 16'h8005);
    endproperty
    a_crc16_known_vector: assert property (p_crc16_known_vector) else $error("crc16 polynomial wrong");

    property p_crc32_word;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_crc32 && pstrb == 4'hF && !crc32_reset_pending) |=> (crc32_value == $past(next_crc32));
    endproperty
    a_crc32_word: assert property (p_crc32_word) else $error("crc32 word not folded");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && (hit_input || hit_xor || hit_scratch)) |=> (prdata[31:8] == 24'h000000);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_seed_halves;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_result && pstrb[1:0] == 2'b01 && !clear_pending) |=> $stable(crc16_value[15:8]);
    endproperty
    a_seed_halves: assert property (p_seed_halves) else $error("byte seed touched upper half");

    property p_pready_pulse;
        @(posedge pclk) disable iff (!presetn)
        pready |=> !pready;
    endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready held two cycles");

    property p_err_ready;
        @(posedge pclk) disable iff (!presetn)
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("slave error without pready");

    property p_unmapped_read;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && !mapped) |=> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

    property p_crc32_partial;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_crc32 && pstrb != 4'hF && !crc32_reset_pending) |=> $stable(crc32_value);
    endproperty
    a_crc32_partial: assert property (p_crc32_partial) else $error("partial crc32 write folded");

    property p_scratch_keep;
        @(posedge pclk) disable iff (!presetn)
        crc32_reset_pending |=> $stable(crc32_scratch);
    endproperty
    a_scratch_keep: assert property (p_scratch_keep) else $error("reinit touched scratch byte");

    property p_ctrl_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && hit_ctrl) |=> (prdata[31:3] == 29'h0000_0000);
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control reserved bits not zero");

    property p_result_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && hit_result) |=> (prdata[31:16] == 16'h0000);
    endproperty
    a_result_rsvd: assert property (p_result_rsvd) else $error("result reserved bits not zero");

    property p_reset_rsvd;
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && hit_reset) |=> (prdata[31:1] == 31'h0000_0000);
    endproperty
    a_reset_rsvd: assert property (p_reset_rsvd) else $error("reinit reserved bits not zero");

    property p_order_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_ctrl && pstrb[0]) |=> (bit_order == $past(pwdata[1]));
    endproperty
    a_order_write: assert property (p_order_write) else $error("bit order not stored");

    property p_xor_load;
        @(posedge pclk) disable iff (!presetn)
        (wr_done && hit_xor && pstrb[0]) |=> (xor_value == $past(pwdata[7:0]));
    endproperty
    a_xor_load: assert property (p_xor_load) else $error("checksum seed not loaded");

    property p_prdata_hold;
        @(posedge pclk) disable iff (!presetn)
        !(access && !pready && !pwrite) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved outside a read");

    c_crc16_input: cover property (@(posedge pclk) disable iff (!presetn) wr_done && hit_input);
    c_crc16_clear: cover property (@(posedge pclk) disable iff (!presetn) clear_pending);
    c_crc32_reinit: cover property (@(posedge pclk) disable iff (!presetn) crc32_reset_pending);
    c_lsb_first_input: cover property (@(posedge pclk) disable iff (!presetn) wr_done && hit_input && bit_order);
endmodule

/* File: core/crc_unit_pkg.sv */
/*
 * Constants for the checksum unit: register byte offsets, field positions,
 * reset values and generator polynomials.
 * Assumes a 32-bit APB with an 8-bit byte address and byte strobes.
 */
package crc_unit_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] off_crc32_result_data = 8'h00;
    localparam logic [7:0] off_crc32_scratch = 8'h04;
    localparam logic [7:0] off_crc32_engine_reset_control = 8'h08;
    localparam logic [7:0] off_crc16_control = 8'h0C;
    localparam logic [7:0] off_crc16_input_byte = 8'h10;
    localparam logic [7:0] off_crc16_result = 8'h14;
    localparam logic [7:0] off_xor_checksum_result = 8'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int crc32_reset_pos = 0;
    localparam int input_bit_order_select_pos = 1;
    localparam int crc16_clear_bit_pos = 2;

    // ------------------------------------------------------------
    // reset values and polynomials
    // ------------------------------------------------------------
    localparam logic [31:0] crc32_init = 32'hFFFF_FFFF;
    localparam logic [15:0] crc16_reset_value = 16'h0000;
    localparam logic [7:0] byte_reset_value = 8'h00;
    localparam logic [15:0] crc16_poly = 16'h8005;
    localparam logic [31:0] crc32_poly = 32'h04C1_1DB7;
    localparam logic [3:0] strobe_word = 4'hF;
endpackage

/* File: core/crc16_byte_step.sv */
/*
 * One CRC16 step over a single byte, purely combinational.
 * Assumes the caller registers the result; no final XOR; input bits reflected only when lsb_first is set, output never reflected.
 */
`timescale 1ns/1ns
module crc16_byte_step (
    input wire logic [7:0] data,
    input wire logic lsb_first,
    input wire logic [15:0] crc_in,
    output logic [15:0] crc_out
);
    logic [15:0] chain [0:8];

    assign chain[0] = crc_in;

    // ------------------------------------------------------------
    // eight serial shifts, bit order picked per input byte only
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            logic in_bit;
            logic fb;
            assign in_bit = lsb_first ? data[i] : data[7 - i];
            assign fb = chain[i][15] ^ in_bit;
            assign chain[i + 1] = {chain[i][14:0], 1'b0} ^ (fb ? crc_unit_pkg::crc16_poly : 16'h0000);
        end
    endgenerate

    assign crc_out = chain[8];
endmodule

/* File: core/crc32_word_step.sv */
/*
 * One CRC32 step over a whole 32-bit word, MSB first, purely combinational.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ns
module crc32_word_step (
    input wire logic [31:0] data,
    input wire logic [31:0] crc_in,
    output logic [31:0] crc_out
);
    logic [31:0] chain [0:32];

    assign chain[0] = crc_in;

    genvar i;
    generate
        for (i = 0; i < 32; i++) begin : g_bit
            logic fb;
            assign fb = chain[i][31] ^ data[31 - i];
            assign chain[i + 1] = {chain[i][30:0], 1'b0} ^ (fb ? crc_unit_pkg::crc32_poly : 32'h0000_0000);
        end
    endgenerate

    assign crc_out = chain[32];
endmodule

/* File: tb/crc_unit_tb.sv */
/*
 * Self-checking bench for crc_unit: APB master tasks, CRC16/CRC32 models, table of expected XOR checksums.
 * Assumes a 10 MHz pclk and an APB slave that answers with pready.
 */
`timescale 1ns/1ns
module crc_unit_tb;
    typedef struct packed {
        logic lsb;
        logic [7:0] data;
        logic [7:0] lrc;
    } row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int err_count = 0;
    int n_checks = 0;
    logic [15:0] crc16;
    logic [31:0] crc32;
    logic [31:0] rdv;
    logic erv;
    // bit order, input byte, checksum expected after that byte
    row_t rows [6] = '{'{1'b0, 8'h01, 8'h5B}, '{1'b1, 8'h01, 8'h5A}, '{1'b0, 8'hA5, 8'hFF},
                       '{1'b1, 8'h3C, 8'hC3}, '{1'b0, 8'hFF, 8'h3C}, '{1'b1, 8'h80, 8'hBC}};
    logic [31:0] rst_exp [7] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    crc_unit dut_u (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr)
    );

    always #50 pclk = ~pclk;

    // ------------------------------------------------------------
    // reference models
    // ------------------------------------------------------------
    function automatic logic [15:0] crc16_step(input logic [15:0] c, input logic [7:0] d, input logic lsb);
        logic b;
        for (int i = 0; i < 8; i++) begin
            b = lsb ? d[i] : d[7 - i];
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? 16'h8005 : 16'h0000);
        end
        return c;
    endfunction

    function automatic logic [31:0] crc32_step(input logic [31:0] c, input logic [31:0] d);
        for (int i = 0; i < 32; i++) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[31 - i]) ? 32'h04C1_1DB7 : 32'h0000_0000);
        end
        return c;
    endfunction

    // ------------------------------------------------------------
    // compare, report and bus tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d, errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: data %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: slave error %b, expected %b", $time, got, exp);
        end
    endtask

    // one transfer, then one idle cycle so side effects settle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= w ? s : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin
                err_count++;
                $display("CHECK FAILED at %0t: no pready", $time);
                finish_test();
            end
            @(posedge pclk);
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        apb(1'b1, a, d, s);
        chk_bit(erv, 1'b0);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        chk_bit(erv, 1'b0);
        chk_val(rdv, exp);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(8'h18, 32'h0000_005A, 4'h1);
        wr(8'h14, 32'h0000_0034, 4'h1);
        wr(8'h14, 32'h0000_1200, 4'h2);
        crc16 = 16'h1234;
        rd_chk(8'h14, 32'h0000_1234);
        foreach (rows[i]) begin
            wr(8'h0C, {29'h0, 1'b0, rows[i].lsb, 1'b1}, 4'hF);
            rd_chk(8'h0C, {30'h0, rows[i].lsb, 1'b0});
            rd_chk(8'h14, {16'h0000, crc16});
            wr(8'h10, {24'hABCDEF, rows[i].data}, 4'hF);
            crc16 = crc16_step(crc16, rows[i].data, rows[i].lsb);
            rd_chk(8'h14, {16'h0000, crc16});
            rd_chk(8'h18, {24'h000000, rows[i].lrc});
        end
        // halfword seed, byte-strobed input
        wr(8'h14, 32'hFFFF_BEEF, 4'h3);
        rd_chk(8'h14, 32'h0000_BEEF);
        wr(8'h10, 32'h0000_0080, 4'h1);
        rd_chk(8'h14, {16'h0000, crc16_step(16'hBEEF, 8'h80, 1'b1)});
        // clear pulse with msb first: reads zero, result zero, known vector after
        wr(8'h0C, 32'hFFFF_FFFC, 4'hF);
        rd_chk(8'h0C, 32'h0000_0000);
        rd_chk(8'h14, 32'h0000_0000);
        wr(8'h10, 32'h0000_0001, 4'h1);
        rd_chk(8'h14, 32'h0000_8005);
        wr(8'h18, 32'h0000_0000, 4'h1);
        rd_chk(8'h18, 32'h0000_0000);
        // crc32 word, ignored partial write, reinit
        crc32 = crc32_step(32'hFFFF_FFFF, 32'h1234_5678);
        wr(8'h00, 32'h1234_5678, 4'hF);
        rd_chk(8'h00, crc32);
        wr(8'h00, 32'hFFFF_0000, 4'h3);
        rd_chk(8'h00, crc32);
        wr(8'h04, 32'h0000_00A5, 4'h1);
        wr(8'h08, 32'h0000_0001, 4'hF);
        rd_chk(8'h00, 32'hFFFF_FFFF);
        rd_chk(8'h08, 32'h0000_0000);
        rd_chk(8'h04, 32'h0000_00A5);
        wr(8'h00, 32'hCAFE_F00D, 4'hF);
        rd_chk(8'h00, crc32_step(32'hFFFF_FFFF, 32'hCAFE_F00D));
        // unmapped address
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF);
        chk_bit(erv, 1'b1);
        apb(1'b0, 8'h1C, 32'h0000_0000, 4'h0);
        chk_bit(erv, 1'b1);
        chk_val(rdv, 32'h0000_0000);
        // reset in mid-run, then every reset value
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 7; i++) begin
            rd_chk(8'(i * 4), rst_exp[i]);
        end
        finish_test();
    end
endmodule
